// ---- verilog/jps_pkg.sv ----
package jps_pkg;

  // ****************************************
  // instruction and tap decode
  // ****************************************
  typedef enum logic [2:0] {
    OTHER_INSTR = 3'h0,
    TARGET_RESET_INSTR = 3'h1,
    PROG_UNLOCK_INSTR = 3'h2,
    PROG_COMMAND_INSTR = 3'h3,
    PAGE_FILL_INSTR = 3'h4,
    PAGE_DUMP_INSTR = 3'h5
  } jps_ir_t;

  typedef struct packed {
    logic capture;
    logic shift;
    logic update;
  } jps_tap_t;

  // ****************************************
  // array requests
  // ****************************************
  typedef enum logic [3:0] {
    NVM_NOP = 4'h0,
    NVM_RD_FLASH = 4'h1,
    NVM_RD_EEPROM = 4'h2,
    NVM_LD_FLASH = 4'h3,
    NVM_LD_EEPROM = 4'h4,
    NVM_WR_FLASH_PAGE = 4'h5,
    NVM_WR_EEPROM_PAGE = 4'h6,
    NVM_ERASE = 4'h7,
    NVM_WR_FUSE_LO = 4'h8,
    NVM_WR_FUSE_HI = 4'h9,
    NVM_WR_LOCK = 4'ha
  } jps_nvm_op_t;

  typedef struct packed {
    logic valid;
    jps_nvm_op_t op;
    logic [15:0] addr;
    logic [15:0] wdata;
  } jps_nvm_req_t;

  // ****************************************
  // constants
  // ****************************************
  localparam logic [15:0] UNLOCK_KEY = 16'ha370;
  localparam int CMD_W = 15;
  localparam int STATUS_BIT = 9;
  localparam logic [2:0] BYTE_LAST = 3'h7;
  localparam logic [7:0] SIG_NONE = 8'hff;
  localparam jps_nvm_req_t NVM_REQ_RST = '0;
  // command word opcodes, upper seven bits
  localparam logic [6:0] OP_ENTER = 7'h23;
  localparam logic [6:0] OP_ADDR_HI = 7'h07;
  localparam logic [6:0] OP_ADDR_LO = 7'h03;
  localparam logic [6:0] OP_DATA_LO = 7'h13;
  localparam logic [6:0] OP_DATA_HI = 7'h17;
  localparam logic [6:0] OP_LATCH = 7'h77;
  localparam logic [6:0] OP_WR_LO = 7'h31;
  localparam logic [6:0] OP_WR_HI = 7'h35;
  localparam logic [6:0] OP_RD_LO = 7'h32;
  localparam logic [6:0] OP_RD_HI = 7'h36;
  localparam logic [6:0] OP_RD_FH = 7'h3e;
  // mode bytes carried by the enter opcode
  localparam logic [7:0] MODE_NOP = 8'h00;
  localparam logic [7:0] MODE_ERASE = 8'h80;
  localparam logic [7:0] MODE_FLASH_WR = 8'h10;
  localparam logic [7:0] MODE_FLASH_RD = 8'h02;
  localparam logic [7:0] MODE_EE_WR = 8'h11;
  localparam logic [7:0] MODE_EE_RD = 8'h03;
  localparam logic [7:0] MODE_FUSE_WR = 8'h40;
  localparam logic [7:0] MODE_LOCK_WR = 8'h20;
  localparam logic [7:0] MODE_FUSE_RD = 8'h04;
  localparam logic [7:0] MODE_SIG_RD = 8'h08;

endpackage

// ---- verilog/jps_sync.sv ----
`timescale 1ns/1ps
module jps_sync #(
  parameter int W = 1
) (
  // destination clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // levels in and out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_reg;

  // two flop synchroniser, meta stage read only by q
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule

// ---- verilog/jps_byte_shift.sv ----
`timescale 1ns/1ps
module jps_byte_shift (
  // link clock and reset
  input wire logic tck,
  input wire logic rst_b,
  // chain control
  input wire logic clear,
  input wire logic shift_en,
  input wire logic sin,
  input wire logic load_en,
  input wire logic [7:0] load_val,
  // chain outputs
  output logic sout,
  output logic [7:0] byte_out,
  output logic byte_tgl
);

  logic [7:0] sh_reg;
  logic [7:0] sh_next;
  logic [2:0] cnt_reg;
  logic wrap;

  assign sh_next = {sin, sh_reg[7:1]};
  assign sout = sh_reg[0];
  assign wrap = shift_en && !clear && (cnt_reg == jps_pkg::BYTE_LAST);

  // bit counter inside the current byte
  always_ff @(posedge tck or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= 3'h0;
    end else if (clear) begin
      cnt_reg <= 3'h0;
    end else if (shift_en) begin
      cnt_reg <= cnt_reg + 3'h1;
    end
  end

  // shifter, reloaded at each byte boundary when loading
  always_ff @(posedge tck or negedge rst_b) begin
    if (!rst_b) begin
      sh_reg <= 8'h00;
    end else if (clear) begin
      sh_reg <= 8'h00;
    end else if (wrap && load_en) begin
      sh_reg <= load_val;
    end else if (shift_en) begin
      sh_reg <= sh_next;
    end
  end

  // completed byte and its toggle event
  always_ff @(posedge tck or negedge rst_b) begin
    if (!rst_b) begin
      byte_out <= 8'h00;
      byte_tgl <= 1'b0;
    end else if (wrap) begin
      byte_out <= sh_next;
      byte_tgl <= ~byte_tgl;
    end
  end

  property p_fill_byte;
    @(posedge tck) disable iff (!rst_b)
    wrap |=> (byte_tgl != $past(byte_tgl)) && (byte_out == $past(sh_next));
  endproperty
  a_fill_byte: assert property (p_fill_byte)
    else $error("completed byte not handed over");

  property p_dump_load;
    @(posedge tck) disable iff (!rst_b)
    (wrap && load_en) |=> (sh_reg == $past(load_val)) &&
      (sout == $past(load_val[0]));
  endproperty
  a_dump_load: assert property (p_dump_load)
    else $error("dump byte not loaded at byte boundary");

  property p_lsb_first;
    @(posedge tck) disable iff (!rst_b)
    (shift_en && !clear && !(wrap && load_en)) |=> sout == $past(sh_reg[1]);
  endproperty
  a_lsb_first: assert property (p_lsb_first)
    else $error("chain not shifting lsb first");

endmodule

// ---- verilog/jps_top.sv ----
`timescale 1ns/1ps
module jps_top #(
  parameter int FLASH_AW = 14,
  parameter int EEPROM_AW = 10,
  parameter logic [7:0] SIG_BYTE0 = 8'h5a, // arbitrary value
  parameter logic [7:0] SIG_BYTE1 = 8'h3c, // arbitrary value
  parameter logic [7:0] SIG_BYTE2 = 8'h0f  // arbitrary value
) (
  // system clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // link side from the tap controller
  input wire logic tck,
  input wire logic tdi,
  input wire jps_pkg::jps_ir_t ir_sel,
  input wire jps_pkg::jps_tap_t tap,
  output logic tdo,
  // array side
  output jps_pkg::jps_nvm_req_t nvm_req,
  input wire logic [15:0] nvm_rdata,
  input wire logic nvm_busy,
  input wire logic [7:0] fuse_hi_in,
  input wire logic [7:0] fuse_lo_in,
  input wire logic [7:0] lock_in,
  input wire logic [7:0] cal_in,
  // status
  output logic target_reset,
  output logic prog_active
);

  if (FLASH_AW < 1 || FLASH_AW > 16 || EEPROM_AW < 1 || EEPROM_AW > 16)
  begin : g_bad_width
    $error("address widths must lie in 1..16");
  end

  // ****************************************
  // helpers
  // ****************************************
  // drops address bits above the implemented width
  function automatic logic [15:0] jps_mask(input logic [15:0] a,
                                           input int bits);
    jps_mask = a & 16'((32'h1 << bits) - 32'h1);
  endfunction

  // ****************************************
  // link domain
  // ****************************************
  logic busy_t;
  logic reset_sh_reg;
  logic target_reset_tck_reg;
  logic [15:0] key_sh_reg;
  logic unlock_reg;
  logic [14:0] cmd_sh_reg;
  logic [14:0] cmd_word_reg;
  logic cmd_tgl_reg;
  logic fill_sout;
  logic [7:0] fill_byte;
  logic fill_tgl;
  logic dump_sout;
  logic dump_tgl;
  logic [7:0] resp_reg;
  logic [7:0] dump_byte_reg;
  logic sel_reset;
  logic sel_key;
  logic sel_cmd;
  logic sel_fill;
  logic sel_dump;

  assign sel_reset = ir_sel == jps_pkg::TARGET_RESET_INSTR;
  assign sel_key = ir_sel == jps_pkg::PROG_UNLOCK_INSTR;
  assign sel_cmd = ir_sel == jps_pkg::PROG_COMMAND_INSTR;
  assign sel_fill = ir_sel == jps_pkg::PAGE_FILL_INSTR;
  assign sel_dump = ir_sel == jps_pkg::PAGE_DUMP_INSTR;

  // busy level brought into the link domain
  jps_sync #(.W(1)) u_busy_sync (
    .clk(tck),
    .rst_b(rst_b),
    .d(nvm_busy),
    .q(busy_t)
  );

  // target reset chain
  always_ff @(posedge tck or negedge rst_b) begin
    if (!rst_b) begin
      reset_sh_reg <= 1'b0;
      target_reset_tck_reg <= 1'b0;
    end else if (sel_reset) begin
      if (tap.capture) begin
        reset_sh_reg <= target_reset_tck_reg;
      end else if (tap.shift) begin
        reset_sh_reg <= tdi;
      end else if (tap.update) begin
        target_reset_tck_reg <= reset_sh_reg;
      end
    end
  end

  // unlock key chain
  always_ff @(posedge tck or negedge rst_b) begin
    if (!rst_b) begin
      key_sh_reg <= 16'h0000;
      unlock_reg <= 1'b0;
    end else if (sel_key) begin
      if (tap.capture) begin
        key_sh_reg <= 16'h0000;
      end else if (tap.shift) begin
        key_sh_reg <= {tdi, key_sh_reg[15:1]};
      end else if (tap.update) begin
        unlock_reg <= (key_sh_reg == jps_pkg::UNLOCK_KEY) &&
                      target_reset_tck_reg;
      end
    end
  end

  // command chain, captures status and last read byte
  always_ff @(posedge tck or negedge rst_b) begin
    if (!rst_b) begin
      cmd_sh_reg <= 15'h0000;
      cmd_word_reg <= 15'h0000;
      cmd_tgl_reg <= 1'b0;
    end else if (sel_cmd) begin
      if (tap.capture) begin
        cmd_sh_reg <= {5'h00, !busy_t, 1'b0, resp_reg};
      end else if (tap.shift) begin
        cmd_sh_reg <= {tdi, cmd_sh_reg[14:1]};
      end else if (tap.update && unlock_reg) begin
        cmd_word_reg <= cmd_sh_reg;
        cmd_tgl_reg <= ~cmd_tgl_reg;
      end
    end
  end

  // page fill chain
  jps_byte_shift u_fill (
    .tck(tck),
    .rst_b(rst_b),
    .clear(sel_fill && tap.capture),
    .shift_en(sel_fill && tap.shift && unlock_reg),
    .sin(tdi),
    .load_en(1'b0),
    .load_val(8'h00),
    .sout(fill_sout),
    .byte_out(fill_byte),
    .byte_tgl(fill_tgl)
  );

  // page dump chain, first byte arrives after eight shifts
  jps_byte_shift u_dump (
    .tck(tck),
    .rst_b(rst_b),
    .clear(sel_dump && tap.capture),
    .shift_en(sel_dump && tap.shift && unlock_reg),
    .sin(tdi),
    .load_en(1'b1),
    .load_val(dump_byte_reg),
    .sout(dump_sout),
    .byte_out(),
    .byte_tgl(dump_tgl)
  );

  // serial output of the selected chain
  always_comb begin
    tdo = 1'b0;
    unique case (ir_sel)
      jps_pkg::TARGET_RESET_INSTR: tdo = reset_sh_reg;
      jps_pkg::PROG_UNLOCK_INSTR: tdo = key_sh_reg[0];
      jps_pkg::PROG_COMMAND_INSTR: tdo = cmd_sh_reg[0];
      jps_pkg::PAGE_FILL_INSTR: tdo = fill_sout;
      jps_pkg::PAGE_DUMP_INSTR: tdo = dump_sout;
      default: tdo = 1'b0;
    endcase
  end

  property p_unlock_key;
    @(posedge tck) disable iff (!rst_b)
    (sel_key && tap.update && key_sh_reg != jps_pkg::UNLOCK_KEY)
      |=> !unlock_reg;
  endproperty
  a_unlock_key: assert property (p_unlock_key)
    else $error("unlocked with a wrong key");

  property p_poll_bit;
    @(posedge tck) disable iff (!rst_b)
    (sel_cmd && tap.capture)
      |=> cmd_sh_reg[jps_pkg::STATUS_BIT] == !$past(busy_t);
  endproperty
  a_poll_bit: assert property (p_poll_bit)
    else $error("poll bit does not reflect completion");

  // ****************************************
  // system domain
  // ****************************************
  logic [4:0] xs;
  logic [2:0] tgl_prev_reg;
  logic unlock_s;
  logic cmd_ok;
  logic fill_ok;
  logic dump_ok;
  logic [6:0] op;
  logic [7:0] dat;
  logic [7:0] mode_reg;
  logic [15:0] addr_reg;
  logic [15:0] data_reg;
  logic [15:0] byte_idx_reg;
  logic [15:0] rword_reg;
  logic rd_pend_reg;
  logic rd_dump_reg;
  logic rd_take_reg;
  logic rd_take_dump_reg;
  jps_pkg::jps_nvm_req_t req_next;
  logic rd_dump_next;
  logic [15:0] fl_addr;
  logic [15:0] ee_addr;

  // levels and toggles from the link domain
  jps_sync #(.W(5)) u_link_sync (
    .clk(clk),
    .rst_b(rst_b),
    .d({unlock_reg, target_reset_tck_reg, cmd_tgl_reg, fill_tgl, dump_tgl}),
    .q(xs)
  );

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tgl_prev_reg <= 3'h0;
    end else begin
      tgl_prev_reg <= xs[2:0];
    end
  end

  assign unlock_s = xs[4];
  assign target_reset = xs[3];
  assign prog_active = xs[4];
  assign op = cmd_word_reg[14:8];
  assign dat = cmd_word_reg[7:0];
  assign cmd_ok = (xs[2] ^ tgl_prev_reg[2]) && unlock_s;
  assign fill_ok = (xs[1] ^ tgl_prev_reg[1]) && unlock_s &&
                   mode_reg == jps_pkg::MODE_FLASH_WR;
  assign dump_ok = (xs[0] ^ tgl_prev_reg[0]) && unlock_s &&
                   mode_reg == jps_pkg::MODE_FLASH_RD;
  assign fl_addr = jps_mask(addr_reg + {1'b0, byte_idx_reg[15:1]}, FLASH_AW);
  assign ee_addr = jps_mask(addr_reg, EEPROM_AW);

  // mode, address and data latches
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_reg <= jps_pkg::MODE_NOP;
      addr_reg <= 16'h0000;
      data_reg <= 16'h0000;
    end else if (cmd_ok) begin
      if (op == jps_pkg::OP_ENTER) mode_reg <= dat;
      if (op == jps_pkg::OP_ADDR_HI) addr_reg[15:8] <= dat;
      if (op == jps_pkg::OP_ADDR_LO) addr_reg[7:0] <= dat;
      if (op == jps_pkg::OP_DATA_LO) data_reg[7:0] <= dat;
      if (op == jps_pkg::OP_DATA_HI) data_reg[15:8] <= dat;
    end else if (fill_ok && !byte_idx_reg[0]) begin
      data_reg[7:0] <= fill_byte;
    end
  end

  // byte index inside the page
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      byte_idx_reg <= 16'h0000;
    end else if (cmd_ok && op == jps_pkg::OP_ADDR_LO) begin
      byte_idx_reg <= 16'h0000;
    end else if (fill_ok || dump_ok) begin
      byte_idx_reg <= byte_idx_reg + 16'h0001;
    end
  end

  // next array request
  always_comb begin
    req_next = jps_pkg::NVM_REQ_RST;
    rd_dump_next = 1'b0;
    if (cmd_ok) begin
      unique case (op)
        jps_pkg::OP_LATCH: begin
          if (mode_reg == jps_pkg::MODE_FLASH_WR) begin
            req_next = '{1'b1, jps_pkg::NVM_LD_FLASH, fl_addr, data_reg};
          end else if (mode_reg == jps_pkg::MODE_EE_WR) begin
            req_next = '{1'b1, jps_pkg::NVM_LD_EEPROM, ee_addr,
                         {8'h00, data_reg[7:0]}};
          end
        end
        jps_pkg::OP_WR_LO: begin
          if (mode_reg == jps_pkg::MODE_ERASE) begin
            req_next = '{1'b1, jps_pkg::NVM_ERASE, 16'h0000, 16'h0000};
          end else if (mode_reg == jps_pkg::MODE_EE_WR) begin
            req_next = '{1'b1, jps_pkg::NVM_WR_EEPROM_PAGE, ee_addr, 16'h0000};
          end else if (mode_reg == jps_pkg::MODE_FUSE_WR) begin
            req_next = '{1'b1, jps_pkg::NVM_WR_FUSE_LO, 16'h0000,
                         {8'h00, data_reg[7:0]}};
          end else if (mode_reg == jps_pkg::MODE_LOCK_WR) begin
            req_next = '{1'b1, jps_pkg::NVM_WR_LOCK, 16'h0000,
                         {8'h00, lock_in & data_reg[7:0]}};
          end
        end
        jps_pkg::OP_WR_HI: begin
          if (mode_reg == jps_pkg::MODE_FLASH_WR) begin
            req_next = '{1'b1, jps_pkg::NVM_WR_FLASH_PAGE, fl_addr, 16'h0000};
          end else if (mode_reg == jps_pkg::MODE_FUSE_WR) begin
            req_next = '{1'b1, jps_pkg::NVM_WR_FUSE_HI, 16'h0000,
                         {8'h00, data_reg[7:0]}};
          end
        end
        jps_pkg::OP_RD_LO: begin
          if (mode_reg == jps_pkg::MODE_FLASH_RD) begin
            req_next = '{1'b1, jps_pkg::NVM_RD_FLASH, fl_addr, 16'h0000};
          end else if (mode_reg == jps_pkg::MODE_EE_RD) begin
            req_next = '{1'b1, jps_pkg::NVM_RD_EEPROM, ee_addr, 16'h0000};
          end
        end
        jps_pkg::OP_ADDR_LO: begin
          if (mode_reg == jps_pkg::MODE_FLASH_RD) begin
            req_next = '{1'b1, jps_pkg::NVM_RD_FLASH,
                         jps_mask({addr_reg[15:8], dat}, FLASH_AW), 16'h0000};
            rd_dump_next = 1'b1;
          end
        end
        default: req_next = jps_pkg::NVM_REQ_RST;
      endcase
    end else if (fill_ok && byte_idx_reg[0]) begin
      req_next = '{1'b1, jps_pkg::NVM_LD_FLASH, fl_addr,
                   {fill_byte, data_reg[7:0]}};
    end else if (dump_ok && byte_idx_reg[0]) begin
      req_next = '{1'b1, jps_pkg::NVM_RD_FLASH,
                   jps_mask(fl_addr + 16'h0001, FLASH_AW), 16'h0000};
      rd_dump_next = 1'b1;
    end
  end

  // request register and read pipeline
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      nvm_req <= jps_pkg::NVM_REQ_RST;
      rd_pend_reg <= 1'b0;
      rd_dump_reg <= 1'b0;
      rd_take_reg <= 1'b0;
      rd_take_dump_reg <= 1'b0;
    end else begin
      nvm_req <= req_next;
      rd_pend_reg <= req_next.valid &&
                     (req_next.op == jps_pkg::NVM_RD_FLASH ||
                      req_next.op == jps_pkg::NVM_RD_EEPROM);
      rd_dump_reg <= rd_dump_next;
      rd_take_reg <= rd_pend_reg;
      rd_take_dump_reg <= rd_dump_reg;
    end
  end

  // read word holder
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rword_reg <= 16'h0000;
    end else if (rd_take_reg) begin
      rword_reg <= nvm_rdata;
    end
  end

  // byte returned in the next captured command word
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      resp_reg <= 8'h00;
    end else if (rd_take_reg && !rd_take_dump_reg) begin
      resp_reg <= nvm_rdata[7:0];
    end else if (cmd_ok) begin
      if (mode_reg == jps_pkg::MODE_FUSE_RD) begin
        if (op == jps_pkg::OP_RD_FH) resp_reg <= fuse_hi_in;
        if (op == jps_pkg::OP_RD_LO) resp_reg <= fuse_lo_in;
        if (op == jps_pkg::OP_RD_HI) resp_reg <= lock_in;
      end
      if (mode_reg == jps_pkg::MODE_FLASH_RD && op == jps_pkg::OP_RD_HI) begin
        resp_reg <= rword_reg[15:8];
      end
      if (mode_reg == jps_pkg::MODE_SIG_RD) begin
        if (op == jps_pkg::OP_RD_LO) begin
          unique case (addr_reg[1:0])
            2'h0: resp_reg <= SIG_BYTE0;
            2'h1: resp_reg <= SIG_BYTE1;
            2'h2: resp_reg <= SIG_BYTE2;
            default: resp_reg <= jps_pkg::SIG_NONE;
          endcase
        end
        if (op == jps_pkg::OP_RD_HI) resp_reg <= cal_in;
      end
    end
  end

  // next byte for the dump chain
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dump_byte_reg <= 8'h00;
    end else if (rd_take_reg && rd_take_dump_reg) begin
      dump_byte_reg <= nvm_rdata[7:0];
    end else if (dump_ok && !byte_idx_reg[0]) begin
      dump_byte_reg <= rword_reg[15:8];
    end
  end

  property p_locked_ignore;
    @(posedge clk) disable iff (!rst_b)
    ((xs[2] ^ tgl_prev_reg[2]) && !unlock_s && !fill_ok && !dump_ok)
      |=> !nvm_req.valid;
  endproperty
  a_locked_ignore: assert property (p_locked_ignore)
    else $error("command acted on while locked");

  property p_lock_keep;
    @(posedge clk) disable iff (!rst_b)
    (cmd_ok && op == jps_pkg::OP_WR_LO && mode_reg == jps_pkg::MODE_LOCK_WR)
      |=> nvm_req.valid && nvm_req.op == jps_pkg::NVM_WR_LOCK &&
          (nvm_req.wdata[7:0] & ~$past(lock_in)) == 8'h00;
  endproperty
  a_lock_keep: assert property (p_lock_keep)
    else $error("lock write would unprogram a bit");

  property p_addr_mask;
    @(posedge clk) disable iff (!rst_b)
    (nvm_req.valid && nvm_req.op == jps_pkg::NVM_LD_EEPROM)
      |-> (32'(nvm_req.addr) >> EEPROM_AW) == 32'h0;
  endproperty
  a_addr_mask: assert property (p_addr_mask)
    else $error("eeprom address above implemented width");

  property p_read_low;
    @(posedge clk) disable iff (!rst_b)
    (cmd_ok && op == jps_pkg::OP_RD_LO && mode_reg == jps_pkg::MODE_FLASH_RD)
      |=> nvm_req.valid ##2 resp_reg == $past(nvm_rdata[7:0]);
  endproperty
  a_read_low: assert property (p_read_low)
    else $error("flash low byte not returned");

  property p_fill_pair;
    @(posedge clk) disable iff (!rst_b)
    (fill_ok && byte_idx_reg[0])
      |=> nvm_req.valid && nvm_req.op == jps_pkg::NVM_LD_FLASH &&
          nvm_req.wdata[15:8] == $past(fill_byte);
  endproperty
  a_fill_pair: assert property (p_fill_pair)
    else $error("filled word not loaded into page buffer");

  property p_erase;
    @(posedge clk) disable iff (!rst_b)
    (cmd_ok && op == jps_pkg::OP_WR_LO && mode_reg == jps_pkg::MODE_ERASE)
      |=> nvm_req.valid && nvm_req.op == jps_pkg::NVM_ERASE;
  endproperty
  a_erase: assert property (p_erase)
    else $error("chip erase not started");

endmodule

// ---- verif/jps_prog_model.sv ----
`timescale 1ns/1ps
module jps_prog_model (
  // link out
  output logic tck,
  output logic tdi,
  output jps_pkg::jps_ir_t ir_sel,
  output jps_pkg::jps_tap_t tap,
  // link in
  input wire logic tdo
);
  // idle: link clock stands still
  initial begin
    {tck, tdi, tap} = '0;
    ir_sel = jps_pkg::OTHER_INSTR;
  end
  // capture, n shifts lsb first, update
  task scan(input jps_pkg::jps_ir_t ir, input logic [31:0] din,
    input int n, output logic [31:0] dout);
    ir_sel = ir;
    tap = 3'b100;
    #3 tck = 1'b1;
    #3 tck = 1'b0;
    tap = 3'b010;
    for (int i = 0; i < n; i++) begin
      tdi = din[i];
      dout[i] = tdo;
      #3 tck = 1'b1;
      #3 tck = 1'b0;
    end
    tap = 3'b001;
    #3 tck = 1'b1;
    #3 tck = 1'b0;
    tap = '0;
    tdi = ~tdi; // last data bit inverted
    #3; // keeps back-to-back scans apart
  endtask
endmodule

// ---- verif/jps_top_tb.sv ----
`timescale 1ns/1ps
module jps_top_tb;
  logic clk, rst_b, tck, tdi, tdo, nvm_busy, target_reset, prog_active;
  logic [15:0] nvm_rdata = '0;
  logic [31:0] rx;
  jps_pkg::jps_ir_t ir_sel;
  jps_pkg::jps_tap_t tap;
  jps_pkg::jps_nvm_req_t nvm_req;
  jps_pkg::jps_nvm_req_t last = '0;
  int bad_count = 0, checks = 0;
  localparam logic [15:0] K = 16'hc3a5;
  jps_top uut (.clk(clk), .rst_b(rst_b), .tck(tck), .tdi(tdi), .tap(tap),
    .ir_sel(ir_sel), .tdo(tdo), .nvm_req(nvm_req), .nvm_rdata(nvm_rdata),
    .nvm_busy(nvm_busy), .fuse_hi_in(8'hd9), .fuse_lo_in(8'he1),
    .lock_in(8'h3c), .cal_in(8'h6b), .target_reset(target_reset),
    .prog_active(prog_active));
  jps_prog_model pm (.tck(tck), .tdi(tdi), .ir_sel(ir_sel), .tap(tap),
    .tdo(tdo));
  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // array: data tracks last address
  always @(posedge clk) if (nvm_req.valid) last <= nvm_req;
  always @(negedge clk) nvm_rdata <= last.addr ^ K;
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task cmd(input logic [6:0] op, input logic [7:0] d);
    pm.scan(jps_pkg::PROG_COMMAND_INSTR, {17'h0, op, d}, 15, rx);
    repeat (10) @(negedge clk);
  endtask
  task stop_test();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task t_unlock();
    cmd(7'h23, 8'h80);
    cmd(7'h31, 8'h00);
    chk(last.valid, 1'b0);
    pm.scan(jps_pkg::TARGET_RESET_INSTR, 32'h1, 1, rx);
    pm.scan(jps_pkg::PROG_UNLOCK_INSTR, 32'ha371, 16, rx);
    repeat (8) @(negedge clk);
    chk(prog_active, 1'b0);
    pm.scan(jps_pkg::PROG_UNLOCK_INSTR, 32'ha370, 16, rx);
    repeat (8) @(negedge clk);
    chk({target_reset, prog_active}, 2'b11);
  endtask
  task t_erase();
    cmd(7'h23, 8'h80);
    chk(rx[9], 1'b0);
    nvm_busy = 1'b0;
    cmd(7'h31, 8'h00);
    chk(last.op, jps_pkg::NVM_ERASE);
    cmd(7'h23, 8'h02);
    chk(rx[9], 1'b1);
  endtask
  task t_read();
    cmd(7'h07, 8'hff);
    cmd(7'h03, 8'h34);
    cmd(7'h32, 8'h00);
    chk(last.addr, 16'h3f34);
    cmd(7'h36, 8'h00);
    chk(rx[7:0], 8'(16'h3f34 ^ K));
    cmd(7'h07, 8'h01);
    chk(rx[7:0], 8'((16'h3f34 ^ K) >> 8));
  endtask
  task t_dump();
    cmd(7'h03, 8'h00);
    pm.scan(jps_pkg::PAGE_DUMP_INSTR, 32'h0, 24, rx);
    chk(rx[7:0], 8'h00);
    chk(rx[23:8], 16'h0100 ^ K);
  endtask
  task t_fill();
    cmd(7'h23, 8'h10);
    cmd(7'h07, 8'h00);
    cmd(7'h03, 8'h00);
    pm.scan(jps_pkg::PAGE_FILL_INSTR, 32'hbeef, 16, rx);
    repeat (10) @(negedge clk);
    chk(last.op, jps_pkg::NVM_LD_FLASH);
    chk(last.wdata, 16'hbeef);
    cmd(7'h35, 8'h00);
    chk(last.op, jps_pkg::NVM_WR_FLASH_PAGE);
    cmd(7'h13, 8'h34);
    cmd(7'h17, 8'h12);
    cmd(7'h77, 8'h00);
    chk(last.wdata, 16'h1234);
  endtask
  task t_ee();
    cmd(7'h23, 8'h11);
    cmd(7'h03, 8'h05);
    cmd(7'h13, 8'haa);
    cmd(7'h77, 8'h00);
    chk(last.op, jps_pkg::NVM_LD_EEPROM);
    chk(last.wdata, 16'h00aa);
    cmd(7'h31, 8'h00);
    chk(last.op, jps_pkg::NVM_WR_EEPROM_PAGE);
    pm.scan(jps_pkg::PAGE_FILL_INSTR, 32'h5555, 16, rx);
    repeat (10) @(negedge clk);
    chk(last.op, jps_pkg::NVM_WR_EEPROM_PAGE);
    // mode kept, enter word skipped
    cmd(7'h77, 8'h00);
    chk(last.op, jps_pkg::NVM_LD_EEPROM);
  endtask
  task t_leave();
    cmd(7'h23, 8'h00);
    cmd(7'h33, 8'h00);
    pm.scan(jps_pkg::PROG_UNLOCK_INSTR, 32'h0, 16, rx);
    pm.scan(jps_pkg::TARGET_RESET_INSTR, 32'h0, 1, rx);
    repeat (8) @(negedge clk);
    chk({target_reset, prog_active}, 2'b00);
  endtask
  // reset, then the scenarios in order
  initial begin
    rst_b = 1'b0;
    nvm_busy = 1'b1;
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
    t_unlock();
    t_erase();
    t_read();
    t_dump();
    t_fill();
    t_ee();
    t_leave();
    stop_test();
  end
  // hang guard
  initial begin
    #100000;
    bad_count++;
    stop_test();
  end
endmodule
